// [shared/arpr_pkg.sv]
// constants and types for the access control rule port range registers
//
// Contract
// - address select: 0 destination, 1 source
// - equal sense: 0 differ matches, 1 equal
// - offset register picks byte; data register moves it
// - upper bound bytes at 0x02, 0x03, reset zero
// - lower bound high byte at 0x04, reset zero
// - bounds limit tcp port or sequence match
// - lower bound low byte at 0x05, reset zero
// - compare mode: off, either, inside, outside
// - rule mode: off, layer 2, 3, 4
package arpr_pkg;

  // ****************************************
  // direct register addresses
  // ****************************************
  localparam logic [7:0] ADDR_IND_CTRL0 = 8'h6E; // table select and port
  localparam logic [7:0] ADDR_IND_CTRL1 = 8'h6F; // byte offset in rule
  localparam logic [7:0] ADDR_IND_DATA = 8'hA0; // indirect data byte

  // ****************************************
  // fields of the first indirect control register
  // ****************************************
  localparam int TSEL_MSB = 7; // table select field
  localparam int TSEL_LSB = 5;
  localparam int PSEL_MSB = 3; // port number field
  localparam int PSEL_LSB = 0;
  localparam logic [2:0] TABLE_ACL = 3'h2; // code of the rule table

  // ****************************************
  // ports that own a rule entry
  // ****************************************
  localparam int NUM_PORTS = 4;
  localparam logic [3:0] FIRST_PORT = 4'h1; // port numbers start here

  // ****************************************
  // rule byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CMP_CTRL = 8'h01; // layer mode, sel, eq
  localparam logic [7:0] OFF_UPPER_HI = 8'h02;
  localparam logic [7:0] OFF_UPPER_LO = 8'h03;
  localparam logic [7:0] OFF_LOWER_HI = 8'h04;
  localparam logic [7:0] OFF_LOWER_LO = 8'h05;
  localparam logic [7:0] OFF_PORT_CMP = 8'h06; // port compare mode

  // ****************************************
  // field positions inside rule bytes
  // ****************************************
  localparam int MODE_LSB = 4; // rule_layer_mode [5:4]
  localparam int SRC_SEL_BIT = 1; // address select
  localparam int EQ_BIT = 0; // equal_sense
  localparam int PCMP_LSB = 1; // port_compare_mode [2:1]

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic RST_BIT = 1'b0;

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {
    PCMP_OFF = 2'h0, // no port compare
    PCMP_EITHER = 2'h1, // equal to either bound
    PCMP_INSIDE = 2'h2, // inside the range
    PCMP_OUTSIDE = 2'h3 // outside the range
  } arpr_pcmp_t;

  typedef enum logic [1:0] {
    LMODE_OFF = 2'h0, // rule disabled
    LMODE_L2 = 2'h1, // mac header filtering
    LMODE_L3 = 2'h2, // ip address filtering
    LMODE_L4 = 2'h3 // tcp port or protocol filtering
  } arpr_lmode_t;

endpackage

// [verilog/arpr_range_cmp.sv]
// range comparator for one tcp port or sequence value
`timescale 1ns/1ps

module arpr_range_cmp
  import arpr_pkg::*;
(
  // rule side
  input wire logic [15:0] upper,
  input wire logic [15:0] lower,
  input wire arpr_pcmp_t mode,
  // frame side
  input wire logic [15:0] value,
  // result
  output logic hit
);

  // ****************************************
  // comparisons
  // ****************************************
  // unsigned compare, high byte already most significant
  wire logic eq_either = (value == upper) || (value == lower);
  wire logic in_range = (value >= lower) && (value <= upper);

  // ****************************************
  // mode select
  // ****************************************
  // a disabled compare passes, so it never blocks the rest of the rule
  always_comb begin
    unique case (mode)
      PCMP_OFF: hit = 1'b1;
      PCMP_EITHER: hit = eq_either;
      PCMP_INSIDE: hit = in_range;
      PCMP_OUTSIDE: hit = ~in_range;
    endcase
  end

endmodule

// [verilog/arpr_rule_port_range_regs.sv]
// per-port rule bytes for address compare and tcp port range bounds
`timescale 1ns/1ps

module arpr_rule_port_range_regs
  import arpr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // frame under test
  input wire logic frm_valid,
  input wire logic [3:0] frm_port,
  input wire logic [47:0] frm_dest_addr,
  input wire logic [47:0] frm_src_addr,
  input wire logic [47:0] rule_mac_addr,
  input wire logic [15:0] frm_tcp_value,
  // match results
  output logic match_valid,
  output logic addr_hit,
  output logic port_hit,
  output logic [1:0] rule_layer_mode
);

  // ****************************************
  // helpers
  // ****************************************
  // port number to entry index, valid flag alongside
  function automatic logic port_ok(input logic [3:0] pnum);
    port_ok = (pnum >= FIRST_PORT) &&
              (pnum < FIRST_PORT + 4'(NUM_PORTS));
  endfunction

  function automatic logic [1:0] port_idx(input logic [3:0] pnum);
    port_idx = 2'(pnum - FIRST_PORT);
  endfunction

  // ****************************************
  // indirect control registers
  // ****************************************
  logic [7:0] ind_ctrl0; // table select and port number
  logic [7:0] ind_ctrl1; // byte offset within rule

  // ****************************************
  // rule storage, one entry per port
  // ****************************************
  logic [1:0] layer_mode [NUM_PORTS]; // rule_layer_mode
  logic src_sel [NUM_PORTS]; // address select
  logic equal_sense [NUM_PORTS];
  logic [7:0] upper_hi [NUM_PORTS]; // rule_port_range_upper_high
  logic [7:0] upper_lo [NUM_PORTS]; // rule_port_range_upper_low
  logic [7:0] lower_hi [NUM_PORTS]; // rule_port_range_lower_high
  logic [7:0] lower_lo [NUM_PORTS]; // lower bound low byte
  logic [1:0] port_cmp [NUM_PORTS]; // port_compare_mode

  // ****************************************
  // decode
  // ****************************************
  wire logic wr_ctrl0 = reg_wr && (reg_addr == ADDR_IND_CTRL0);
  wire logic wr_ctrl1 = reg_wr && (reg_addr == ADDR_IND_CTRL1);
  // bytes only reach the rule table when the table code is selected
  wire logic acl_sel =
    (ind_ctrl0[TSEL_MSB:TSEL_LSB] == TABLE_ACL);
  wire logic [3:0] sel_port = ind_ctrl0[PSEL_MSB:PSEL_LSB];
  wire logic sel_ok = acl_sel && port_ok(sel_port);
  wire logic [1:0] sel_idx = port_idx(sel_port);
  wire logic wr_data =
    reg_wr && (reg_addr == ADDR_IND_DATA) && sel_ok;

  // ****************************************
  // write of control registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ind_ctrl0 <= RST_BYTE;
      ind_ctrl1 <= RST_BYTE;
    end else begin
      if (wr_ctrl0) begin
        ind_ctrl0 <= reg_wdata;
      end
      if (wr_ctrl1) begin
        ind_ctrl1 <= reg_wdata;
      end
    end
  end

  // ****************************************
  // write of rule bytes, one slice per port
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_entry
      wire logic we = wr_data && (sel_idx == 2'(gi));
      // each byte keeps its value unless its own offset is written
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          layer_mode[gi] <= RST_MODE;
          src_sel[gi] <= RST_BIT;
          equal_sense[gi] <= RST_BIT;
          upper_hi[gi] <= RST_BYTE;
          upper_lo[gi] <= RST_BYTE;
          lower_hi[gi] <= RST_BYTE;
          lower_lo[gi] <= RST_BYTE;
          port_cmp[gi] <= RST_MODE;
        end else if (we) begin
          unique case (ind_ctrl1)
            OFF_CMP_CTRL: begin
              layer_mode[gi] <= reg_wdata[MODE_LSB+1:MODE_LSB];
              src_sel[gi] <= reg_wdata[SRC_SEL_BIT];
              equal_sense[gi] <= reg_wdata[EQ_BIT];
            end
            OFF_UPPER_HI: upper_hi[gi] <= reg_wdata;
            OFF_UPPER_LO: upper_lo[gi] <= reg_wdata;
            OFF_LOWER_HI: lower_hi[gi] <= reg_wdata;
            OFF_LOWER_LO: lower_lo[gi] <= reg_wdata;
            OFF_PORT_CMP: port_cmp[gi] <= reg_wdata[PCMP_LSB+1:PCMP_LSB];
            default: ; // other offsets belong to other rule fields
          endcase
        end
      end
    end
  endgenerate

  // ****************************************
  // read of the addressed rule byte
  // ****************************************
  logic [7:0] rule_byte; // byte at the selected offset
  always_comb begin
    rule_byte = RST_BYTE;
    if (sel_ok) begin
      unique case (ind_ctrl1)
        OFF_CMP_CTRL: begin
          rule_byte[MODE_LSB+1:MODE_LSB] = layer_mode[sel_idx];
          rule_byte[SRC_SEL_BIT] = src_sel[sel_idx];
          rule_byte[EQ_BIT] = equal_sense[sel_idx];
        end
        OFF_UPPER_HI: rule_byte = upper_hi[sel_idx];
        OFF_UPPER_LO: rule_byte = upper_lo[sel_idx];
        OFF_LOWER_HI: rule_byte = lower_hi[sel_idx];
        OFF_LOWER_LO: rule_byte = lower_lo[sel_idx];
        OFF_PORT_CMP: rule_byte[PCMP_LSB+1:PCMP_LSB] = port_cmp[sel_idx];
        default: rule_byte = RST_BYTE; // unheld offsets read zero
      endcase
    end
  end

  wire logic [7:0] rd_mux =
    (reg_addr == ADDR_IND_CTRL0) ? ind_ctrl0 :
    (reg_addr == ADDR_IND_CTRL1) ? ind_ctrl1 :
    (reg_addr == ADDR_IND_DATA) ? rule_byte : RST_BYTE;

  // read data is captured so it stays put between strobes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ****************************************
  // frame matching
  // ****************************************
  wire logic frm_ok = frm_valid && port_ok(frm_port);
  wire logic [1:0] frm_idx = port_idx(frm_port);
  // bounds assembled with the high byte on top
  wire logic [15:0] upper_val =
    {upper_hi[frm_idx], upper_lo[frm_idx]};
  wire logic [15:0] lower_val =
    {lower_hi[frm_idx], lower_lo[frm_idx]};
  wire logic [47:0] cmp_addr =
    src_sel[frm_idx] ? frm_src_addr : frm_dest_addr;
  wire logic addr_same = (cmp_addr == rule_mac_addr);
  // equal sense 1 wants same, 0 wants differ
  wire logic next_addr_hit = ~(addr_same ^ equal_sense[frm_idx]);
  wire logic next_port_hit;

  arpr_range_cmp u_cmp (
    .upper(upper_val),
    .lower(lower_val),
    .mode(arpr_pcmp_t'(port_cmp[frm_idx])),
    .value(frm_tcp_value),
    .hit(next_port_hit)
  );

  // results registered one cycle after the frame sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_valid <= RST_BIT;
      addr_hit <= RST_BIT;
      port_hit <= RST_BIT;
      rule_layer_mode <= RST_MODE;
    end else begin
      match_valid <= frm_ok;
      if (frm_ok) begin
        addr_hit <= next_addr_hit;
        port_hit <= next_port_hit;
        rule_layer_mode <= layer_mode[frm_idx];
      end
    end
  end

endmodule

// [tb/arpr_rule_port_range_regs_asserts.sv]
// checker for the rule port range register block
`timescale 1ns/1ps

module arpr_rule_port_range_regs_asserts
  import arpr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // frame and results
  input wire logic frm_valid,
  input wire logic [3:0] frm_port,
  input wire logic [47:0] frm_dest_addr,
  input wire logic [47:0] frm_src_addr,
  input wire logic [47:0] rule_mac_addr,
  input wire logic [15:0] frm_tcp_value,
  input wire logic match_valid,
  input wire logic addr_hit,
  input wire logic port_hit,
  input wire logic [1:0] rule_layer_mode
);
  // ****************************************
  // shadow of the rule bytes, kept masked
  // ****************************************
  logic [7:0] ctl0, ctl1; // shadow control registers
  logic [7:0] sh [4][8]; // shadow bytes per port
  logic acc_ok, off_ok, take, in_rng, exp_addr, exp_port, unmapped;
  logic [1:0] idx, fi, pm;
  logic [7:0] msk, exp_rd, b1;
  logic [15:0] up, lo;
  assign acc_ok = ctl0[TSEL_MSB:TSEL_LSB] == TABLE_ACL && ctl0[3:0] != 4'h0
    && ctl0[3:0] <= 4'h4;
  assign off_ok = ctl1 >= OFF_CMP_CTRL && ctl1 <= OFF_PORT_CMP;
  assign idx = 2'(ctl0[3:0] - FIRST_PORT);
  assign msk = ctl1 == OFF_CMP_CTRL ? 8'h33 :
    ctl1 == OFF_PORT_CMP ? 8'h06 : 8'hFF;
  assign exp_rd = (acc_ok && off_ok) ? sh[idx][ctl1[2:0]] : 8'h00;
  assign unmapped = reg_addr != ADDR_IND_CTRL0 && reg_addr != ADDR_IND_CTRL1
    && reg_addr != ADDR_IND_DATA;
  // frame expectation from the shadow of the sampled port
  assign take = frm_valid && frm_port != 4'h0 && frm_port <= 4'h4;
  assign fi = 2'(frm_port - FIRST_PORT);
  assign b1 = sh[fi][1];
  assign up = {sh[fi][2], sh[fi][3]};
  assign lo = {sh[fi][4], sh[fi][5]};
  assign pm = sh[fi][6][2:1];
  assign exp_addr = (((b1[1] ? frm_src_addr : frm_dest_addr) == rule_mac_addr)
    == b1[0]);
  assign in_rng = lo <= frm_tcp_value && frm_tcp_value <= up;
  assign exp_port = pm == 2'h0 ? 1'b1 : pm == 2'h1 ? (frm_tcp_value == up ||
    frm_tcp_value == lo) : pm == 2'h2 ? in_rng : !in_rng;
  // shadow update; a data write only lands when table and port are legal
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl0 <= 8'h00;
      ctl1 <= 8'h00;
      for (int i = 0; i < 32; i++) sh[i / 8][i % 8] <= RST_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_IND_CTRL0) ctl0 <= reg_wdata;
      if (reg_addr == ADDR_IND_CTRL1) ctl1 <= reg_wdata;
      if (reg_addr == ADDR_IND_DATA && acc_ok && off_ok)
        sh[idx][ctl1[2:0]] <= reg_wdata & msk;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_take;
    take;
  endsequence
  // a read strobe aimed at the indirect data byte
  sequence s_rd_data;
    reg_rd && reg_addr == ADDR_IND_DATA;
  endsequence
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_ind_read: assert property (s_rd_data
    |=> reg_rdata == $past(exp_rd)) else $error("indirect byte wrong");
  chk_unmapped_read: assert property (reg_rd && unmapped
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_ctrl_read: assert property (reg_rd && reg_addr == ADDR_IND_CTRL0
    |=> reg_rdata == $past(ctl0)) else $error("control read wrong");
  chk_match_pulse: assert property (s_take |=> match_valid)
    else $error("no result after sample");
  chk_no_match: assert property (!take |=> !match_valid)
    else $error("result without legal sample");
  chk_results_hold: assert property (!take |=>
    $stable({addr_hit, port_hit, rule_layer_mode}))
    else $error("results moved");
  chk_addr_hit: assert property (s_take
    |=> addr_hit == $past(exp_addr)) else $error("address hit wrong");
  chk_port_hit: assert property (s_take
    |=> port_hit == $past(exp_port)) else $error("port hit wrong");
  chk_layer_mode: assert property (s_take |=>
    rule_layer_mode == $past(b1[5:4])) else $error("layer mode wrong");
endmodule

bind arpr_rule_port_range_regs arpr_rule_port_range_regs_asserts u_chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frm_valid(frm_valid),
  .frm_port(frm_port), .frm_dest_addr(frm_dest_addr),
  .frm_src_addr(frm_src_addr), .rule_mac_addr(rule_mac_addr),
  .frm_tcp_value(frm_tcp_value), .match_valid(match_valid),
  .addr_hit(addr_hit), .port_hit(port_hit), .rule_layer_mode(rule_layer_mode)
);

// [tb/arpr_rule_port_range_regs_bench.sv]
// self-checking bench for the rule port range register block
`timescale 1ns/1ps

module arpr_rule_port_range_regs_bench
  import arpr_pkg::*;
();
  logic clk, rst, reg_wr, reg_rd, frm_valid, match_valid, addr_hit, port_hit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] frm_port;
  logic [47:0] dest, src, mac; // mac equals dest, so sel picks the outcome
  logic [15:0] tval;
  logic [1:0] rule_layer_mode;
  logic ea, ep; // last expected hits, reused for the refused sample
  int err_total, n_tests;
  arpr_rule_port_range_regs dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .frm_valid(frm_valid), .frm_port(frm_port),
    .frm_dest_addr(dest), .frm_src_addr(src), .rule_mac_addr(mac),
    .frm_tcp_value(tval), .match_valid(match_valid), .addr_hit(addr_hit),
    .port_hit(port_hit), .rule_layer_mode(rule_layer_mode));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****************************************
  // access tasks; each strobe gets a quiet cycle after it
  // ****************************************
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    chk(nm, 16'(exp), 16'(reg_rdata));
    @(posedge clk);
    #1;
  endtask
  task sel(input logic [3:0] p, input logic [7:0] o);
    wr(ADDR_IND_CTRL0, {TABLE_ACL, 1'b0, p});
    wr(ADDR_IND_CTRL1, o);
  endtask
  task frm(input logic [3:0] p, input logic [15:0] v, input logic ok,
    input logic [1:0] m, input logic a, input logic h);
    frm_port = p;
    tval = v;
    frm_valid = 1'b1;
    @(posedge clk);
    #1 frm_valid = 1'b0;
    chk("match valid", 16'(ok), 16'(match_valid));
    chk("layer mode", 16'(m), 16'(rule_layer_mode));
    chk("addr hit", 16'(a), 16'(addr_hit));
    chk("port hit", 16'(h), 16'(port_hit));
    @(posedge clk);
    #1;
  endtask
  // byte masks and fill pattern
  function automatic logic [7:0] msk(input int o);
    return o == 1 ? 8'h33 : o == 6 ? 8'h06 : 8'hFF;
  endfunction
  function automatic logic [7:0] pat(input int p, input int o);
    return 8'h5A ^ 8'(p * 16 + o * 3);
  endfunction
  // range result for bounds 0x0100..0x1234
  function automatic logic pexp(input int m, input logic [15:0] v);
    logic in_r;
    in_r = v >= 16'h0100 && v <= 16'h1234;
    return m == 0 ? 1'b1 : m == 1 ? (v == 16'h0100 || v == 16'h1234) :
      m == 2 ? in_r : !in_r;
  endfunction
  task results;
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    logic [15:0] vals [6];
    logic [7:0] bnd [4];
    vals = '{16'h0100, 16'h0800, 16'h1234, 16'h2000, 16'h00FF, 16'h1235};
    bnd = '{8'h12, 8'h34, 8'h01, 8'h00};
    {rst, reg_wr, reg_rd, frm_valid} = 4'h8;
    {reg_addr, reg_wdata, frm_port, tval} = 36'h0;
    dest = 48'h0000_1111_2222;
    src = 48'h0000_3333_4444;
    mac = dest;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    for (int p = 1; p <= 4; p++) for (int o = 1; o <= 6; o++) begin
      sel(4'(p), 8'(o));
      rd(ADDR_IND_DATA, RST_BYTE, "reset byte");
    end
    for (int p = 1; p <= 4; p++) for (int o = 1; o <= 6; o++) begin
      sel(4'(p), 8'(o));
      wr(ADDR_IND_DATA, pat(p, o));
    end
    for (int p = 1; p <= 4; p++) for (int o = 1; o <= 6; o++) begin
      sel(4'(p), 8'(o));
      rd(ADDR_IND_DATA, pat(p, o) & msk(o), "rule byte");
    end
    // wrong table code, port 4
    wr(ADDR_IND_CTRL0, 8'h24);
    wr(ADDR_IND_DATA, 8'hEE);
    rd(ADDR_IND_DATA, 8'h00, "wrong table");
    sel(4'h5, 8'h02);
    rd(ADDR_IND_DATA, 8'h00, "bad port");
    sel(4'h1, 8'h07);
    wr(ADDR_IND_DATA, 8'hEE);
    rd(ADDR_IND_DATA, 8'h00, "reserved offset");
    rd(8'h10, 8'h00, "unmapped");
    sel(4'h4, 8'h06);
    rd(ADDR_IND_DATA, pat(4, 6) & 8'h06, "kept byte");
    // control registers read back as written
    rd(ADDR_IND_CTRL0, {TABLE_ACL, 1'b0, 4'h4}, "ctrl0 readback");
    rd(ADDR_IND_CTRL1, OFF_PORT_CMP, "ctrl1 readback");
    for (int o = 2; o <= 5; o++) begin
      sel(4'h2, 8'(o));
      wr(ADDR_IND_DATA, bnd[o - 2]);
    end
    for (int m = 0; m < 4; m++) begin
      sel(4'h2, OFF_CMP_CTRL);
      wr(ADDR_IND_DATA, {2'h0, 2'(m), 2'h0, 2'(m)});
      sel(4'h2, OFF_PORT_CMP);
      wr(ADDR_IND_DATA, {5'h0, 2'(m), 1'b0});
      ea = (((m / 2) ? src : dest) == mac) == 1'(m % 2);
      foreach (vals[i]) begin
        ep = pexp(m, vals[i]);
        frm(4'h2, vals[i], 1'b1, 2'(m), ea, ep);
      end
    end
    frm(4'h5, 16'h0800, 1'b0, 2'h3, ea, ep);
    results;
  end
  initial begin
    #(50 * 4000);
    err_total++;
    results;
  end
endmodule
